//--- csb_core.sv
// Purpose: Processor sequencer for system-control ops, block copy and bus timing
// Assumes: clk is the active clock (system clock or subclock chosen outside)
// Notes:   Byte data always travels on the low lane of the 16-bit bus
`timescale 1ns/10ps

module csb_core
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Internal bus
  output logic                     bus_valid,
  output logic [15:0]              bus_addr,
  output logic                     bus_we,
  output logic                     bus_word,
  output logic [15:0]              bus_wdata,
  input  wire logic [15:0]         bus_rdata,
  // Interrupt request
  input  wire logic                irq_req,
  input  wire logic [15:0]         irq_vector,
  // Mode selects
  input  wire logic [1:0]          run_mode_sel,
  input  wire logic [2:0]          halt_mode_sel,
  // Status
  output csb_pkg::csb_state_t      cpu_state,
  output logic [1:0]               run_mode,
  output logic [2:0]               halt_mode,
  output logic                     sub_clk_sel
);
  import csb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  csb_state_t  state_q;
  csb_step_t   step_q;
  logic [15:0] pc_q;
  logic [7:0]  flags_q;
  logic [15:0] gr_q [0:7];
  logic [15:0] ir_q;
  logic [15:0] vec_addr_q;
  logic [7:0]  cpy_byte_q;
  logic [1:0]  run_mode_q;
  logic [2:0]  halt_mode_q;
  logic        sub_clk_q;
  logic        bus_valid_q;
  logic [15:0] bus_addr_q;
  logic        bus_we_q;
  logic        bus_word_q;
  logic [15:0] bus_wdata_q;
  logic [1:0]  acc_cnt_q;
  logic        acc_done_q;
  logic        acc_periph_q;
  logic        acc_slow_q;
  logic [15:0] acc_rdata_q;
  // Decode and selection
  wire [7:0]  op_code   = ir_q[15:8];
  wire [7:0]  op_imm    = ir_q[7:0];
  wire [2:0]  op_reg    = ir_q[2:0];
  wire [15:0] sp_val    = gr_q[SP_IDX];
  wire [7:0]  copy_cnt  = gr_q[CNT_IDX][7:0];
  wire        irq_ok    = irq_req && !flags_q[FLAG_MASK_BIT];
  wire        acc_free  = !bus_valid_q && !acc_done_q;
  wire        is_decode = (state_q == ST_EXEC) && (step_q == US_DECODE);
  wire        bus_step  = (step_q != US_DECODE);
  wire        irq_take  = (state_q == ST_EXEC) && (step_q == US_FETCH) && irq_ok && acc_free;
  wire        acc_start = ((state_q == ST_EXEC) || (state_q == ST_EXCEPT)) && bus_step
                          && acc_free && !irq_take;
  // Address, direction and data of the access each step needs
  wire        step_push  = (step_q == US_PUSH_PC) || (step_q == US_PUSH_FLAGS);
  wire        step_pop   = (step_q == US_POP_FLAGS) || (step_q == US_POP_PC);
  wire        step_cpy   = (step_q == US_CPY_RD) || (step_q == US_CPY_WR);
  wire [15:0] nxt_addr   = (step_q == US_CPY_RD) ? gr_q[SRC_IDX]
                         : (step_q == US_CPY_WR) ? gr_q[DST_IDX]
                         : step_push ? (sp_val - STACK_STEP)
                         : (step_q == US_VEC) ? vec_addr_q
                         : step_pop ? sp_val : pc_q;
  wire        nxt_we     = (step_q == US_CPY_WR) || step_push;
  wire        nxt_word   = !step_cpy;
  wire [15:0] nxt_wdata  = (step_q == US_CPY_WR) ? {8'h00, cpy_byte_q}
                         : (step_q == US_PUSH_PC) ? pc_q : {flags_q, flags_q};
  wire        nxt_periph = (nxt_addr >= PERIPH_BASE);
  wire        nxt_slow   = ((nxt_addr >= SLOW_A_LO) && (nxt_addr <= SLOW_A_HI))
                          || ((nxt_addr >= SLOW_B_LO) && (nxt_addr <= SLOW_B_HI));

  // Bus access engine; each cycle of clk is one state
  // state counted per clock edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_valid_q  <= 1'b0;
      bus_addr_q   <= 16'h0000;
      bus_we_q     <= 1'b0;
      bus_word_q   <= 1'b0;
      bus_wdata_q  <= 16'h0000;
      acc_cnt_q    <= 2'h0;
      acc_done_q   <= 1'b0;
      acc_periph_q <= 1'b0;
      acc_slow_q   <= 1'b0;
      acc_rdata_q  <= 16'h0000;
    end
    else
    begin
      acc_done_q <= 1'b0;
      if (acc_start)
      begin
        bus_valid_q  <= 1'b1;
        bus_addr_q   <= nxt_addr;
        bus_we_q     <= nxt_we;
        bus_word_q   <= nxt_word && !nxt_periph;
        bus_wdata_q  <= nxt_wdata;
        acc_cnt_q    <= nxt_slow ? SLOW_STATES : FAST_STATES;
        acc_periph_q <= nxt_periph;
        acc_slow_q   <= nxt_slow;
      end
      else if (bus_valid_q)
      begin
        acc_cnt_q <= acc_cnt_q - 2'h1;
        if (acc_cnt_q == 2'h1)
        begin
          bus_valid_q <= 1'b0;
          bus_we_q    <= 1'b0;
          acc_done_q  <= 1'b1;
          acc_rdata_q <= bus_rdata;
        end
      end
    end
  end
  // Sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q     <= ST_RESET;
      step_q      <= US_VEC;
      pc_q        <= 16'h0000;
      flags_q     <= FLAGS_RST;
      ir_q        <= 16'h0000;
      vec_addr_q  <= RST_VEC_ADDR;
      cpy_byte_q  <= 8'h00;
      run_mode_q  <= RUN_HIGH;
      halt_mode_q <= HALT_SLP_HI;
      sub_clk_q   <= 1'b0;
      gr_q        <= '{default: 16'h0000};
    end
    else
    begin
      unique case (state_q)
        ST_RESET:
        begin
          state_q    <= ST_EXCEPT;
          step_q     <= US_VEC;
          vec_addr_q <= RST_VEC_ADDR;
        end
        ST_HALT:
        begin
          if (irq_ok)
          begin
            state_q    <= ST_EXCEPT;
            step_q     <= US_PUSH_PC;
            vec_addr_q <= irq_vector;
          end
        end
        ST_EXCEPT:
        begin
          if (acc_start && step_push)
          begin
            gr_q[SP_IDX] <= sp_val - STACK_STEP;
          end
          if (acc_done_q)
          begin
            unique case (step_q)
              US_PUSH_PC:    step_q <= US_PUSH_FLAGS;
              US_PUSH_FLAGS: step_q <= US_VEC;
              default:
              begin
                pc_q                   <= acc_rdata_q;
                flags_q[FLAG_MASK_BIT] <= 1'b1;
                state_q          <= ST_EXEC;
                step_q           <= US_FETCH;
              end
            endcase
          end
        end
        ST_EXEC:
        begin
          run_mode_q <= run_mode_sel;
          sub_clk_q  <= (run_mode_sel == RUN_SUB);
          unique case (step_q)
            US_FETCH:
            begin
              if (irq_take)
              begin
                state_q    <= ST_EXCEPT;
                step_q     <= US_PUSH_PC;
                vec_addr_q <= irq_vector;
              end
              else if (acc_done_q)
              begin
                ir_q   <= acc_rdata_q;
                pc_q   <= pc_q + PC_STEP;
                step_q <= US_DECODE;
              end
            end
            US_DECODE:
            begin
              step_q <= US_FETCH;
              case (op_code)
                OP_NOP: step_q <= US_FETCH;
                OP_SLEEP:
                begin
                  state_q     <= ST_HALT;
                  halt_mode_q <= halt_mode_sel;
                end
                OP_LOAD_FLAGS_REG: flags_q <= gr_q[op_reg][7:0];
                OP_LOAD_FLAGS_IMM: flags_q <= op_imm;
                OP_STORE_FLAGS: gr_q[op_reg][7:0] <= flags_q;
                OP_AND_FLAGS: flags_q <= flags_q & op_imm;
                OP_OR_FLAGS: flags_q <= flags_q | op_imm;
                OP_XOR_FLAGS: flags_q <= flags_q ^ op_imm;
                OP_RETURN: step_q <= US_POP_FLAGS;
                OP_BLK_COPY: step_q <= (copy_cnt != 8'h00) ? US_CPY_RD : US_FETCH;
                default: step_q <= US_FETCH;
              endcase
            end
            US_CPY_RD:
            begin
              if (acc_done_q)
              begin
                cpy_byte_q <= acc_rdata_q[7:0];
                step_q     <= US_CPY_WR;
              end
            end
            US_CPY_WR:
            begin
              if (acc_done_q)
              begin
                gr_q[SRC_IDX]       <= gr_q[SRC_IDX] + PTR_STEP;
                gr_q[DST_IDX]       <= gr_q[DST_IDX] + PTR_STEP;
                gr_q[CNT_IDX][7:0]  <= copy_cnt - 8'h01;
                step_q              <= (copy_cnt == 8'h01) ? US_FETCH : US_CPY_RD;
              end
            end
            US_POP_FLAGS:
            begin
              if (acc_done_q)
              begin
                flags_q      <= acc_rdata_q[15:8];
                gr_q[SP_IDX] <= sp_val + STACK_STEP;
                step_q       <= US_POP_PC;
              end
            end
            US_POP_PC:
            begin
              if (acc_done_q)
              begin
                pc_q         <= acc_rdata_q;
                gr_q[SP_IDX] <= sp_val + STACK_STEP;
                step_q       <= US_FETCH;
              end
            end
            default: step_q <= US_FETCH;
          endcase
        end
      endcase
    end
  end
  // Outputs
  assign bus_valid   = bus_valid_q;
  assign bus_addr    = bus_addr_q;
  assign bus_we      = bus_we_q;
  assign bus_word    = bus_word_q;
  assign bus_wdata   = bus_wdata_q;
  assign cpu_state   = state_q;
  assign run_mode    = run_mode_q;
  assign halt_mode   = halt_mode_q;
  assign sub_clk_sel = sub_clk_q;
  // Checks
  sequence s_two_state;
    bus_valid_q [*2] ##1 !bus_valid_q;
  endsequence
  sequence s_three_state;
    bus_valid_q [*3] ##1 !bus_valid_q;
  endsequence
  a_fast_access: assert property (
    $rose(bus_valid_q) && !acc_slow_q |-> s_two_state)
    else $error("fast access not two states");
  a_slow_access: assert property (
    $rose(bus_valid_q) && acc_slow_q && acc_periph_q |-> s_three_state)
    else $error("slow peripheral access not three states");
  a_periph_byte: assert property (
    bus_valid_q && acc_periph_q |-> !bus_word_q)
    else $error("word access to peripheral");
  a_nop_only_pc: assert property (
    is_decode && op_code == OP_NOP |=> pc_q == $past(pc_q) && flags_q == $past(flags_q)
      && step_q == US_FETCH)
    else $error("no-op changed state");
  a_fetch_pc_step: assert property (
    state_q == ST_EXEC && step_q == US_FETCH && acc_done_q && !irq_take
      |=> pc_q == $past(pc_q) + PC_STEP)
    else $error("counter not advanced by two");
  a_flags_logic: assert property (
    is_decode && op_code == OP_AND_FLAGS |=> flags_q == ($past(flags_q) & $past(op_imm)))
    else $error("AND flags wrong");
  a_flags_or: assert property (
    is_decode && op_code == OP_OR_FLAGS |=> flags_q == ($past(flags_q) | $past(op_imm)))
    else $error("OR flags wrong");
  a_flags_xor: assert property (
    is_decode && op_code == OP_XOR_FLAGS |=> flags_q == ($past(flags_q) ^ $past(op_imm)))
    else $error("XOR flags wrong");
  a_flags_load: assert property (
    is_decode && op_code == OP_LOAD_FLAGS_IMM |=> flags_q == $past(op_imm))
    else $error("load flags wrong");
  a_sleep_halt: assert property (
    is_decode && op_code == OP_SLEEP |=> state_q == ST_HALT && !bus_valid_q)
    else $error("sleep did not halt");
  a_copy_zero: assert property (
    is_decode && op_code == OP_BLK_COPY && copy_cnt == 8'h00
      |=> step_q == US_FETCH ##1 !(bus_valid_q && bus_we_q))
    else $error("zero count copy moved data");
  a_irq_push: assert property (
    $rose(bus_valid_q) && step_q == US_PUSH_PC
      |-> bus_we_q && bus_addr_q == sp_val && bus_wdata_q == pc_q)
    else $error("interrupt push wrong");
  a_rte_resume: assert property (
    state_q == ST_EXEC && step_q == US_POP_PC && acc_done_q
      |=> pc_q == $past(acc_rdata_q) && sp_val == $past(sp_val) + STACK_STEP)
    else $error("return did not restore counter");
endmodule

//--- csb_pkg.sv
// Purpose: Shared constants and types for the system-control and bus-timing core
// Assumes: 16-bit addresses, 16-bit on-chip memory bus, 8-bit peripheral lane
// Notes:   Opcode values are local encodings of this core
package csb_pkg;

  // Top-level processor states
  typedef enum logic [1:0] {ST_RESET, ST_EXEC, ST_HALT, ST_EXCEPT} csb_state_t;

  // Micro steps of the sequencer
  typedef enum logic [3:0] {
    US_FETCH, US_DECODE, US_CPY_RD, US_CPY_WR, US_PUSH_PC,
    US_PUSH_FLAGS, US_VEC, US_POP_FLAGS, US_POP_PC
  } csb_step_t;

  // Opcodes, high byte of the instruction word
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_SLEEP    = 8'h01;
  localparam logic [7:0] OP_STORE_FLAGS    = 8'h02;
  localparam logic [7:0] OP_LOAD_FLAGS_REG = 8'h03;
  localparam logic [7:0] OP_OR_FLAGS       = 8'h04;
  localparam logic [7:0] OP_XOR_FLAGS      = 8'h05;
  localparam logic [7:0] OP_AND_FLAGS      = 8'h06;
  localparam logic [7:0] OP_LOAD_FLAGS_IMM = 8'h07;
  localparam logic [7:0] OP_RETURN         = 8'h56;
  localparam logic [7:0] OP_BLK_COPY = 8'h7B;

  // Execution and halt mode codes
  localparam logic [1:0] RUN_HIGH     = 2'h0;
  localparam logic [1:0] RUN_MEDIUM   = 2'h1;
  localparam logic [1:0] RUN_SUB      = 2'h2;
  localparam logic [2:0] HALT_SLP_HI  = 3'h0;
  localparam logic [2:0] HALT_SLP_MED = 3'h1;
  localparam logic [2:0] HALT_STANDBY = 3'h2;
  localparam logic [2:0] HALT_WATCH   = 3'h3;
  localparam logic [2:0] HALT_SUBSLP  = 3'h4;

  // Address map and bus timing
  localparam logic [15:0] RST_VEC_ADDR = 16'h0000;
  localparam logic [15:0] PERIPH_BASE  = 16'hFF90;
  localparam logic [15:0] SLOW_A_LO    = 16'hFF98;
  localparam logic [15:0] SLOW_A_HI    = 16'hFF9F;
  localparam logic [15:0] SLOW_B_LO    = 16'hFFA8;
  localparam logic [15:0] SLOW_B_HI    = 16'hFFAF;
  localparam logic [1:0]  FAST_STATES  = 2'h2;
  localparam logic [1:0]  SLOW_STATES  = 2'h3;

  // Register indices, reset values and steps
  localparam logic [2:0]  CNT_IDX    = 3'h4;
  localparam logic [2:0]  SRC_IDX    = 3'h5;
  localparam logic [2:0]  DST_IDX    = 3'h6;
  localparam logic [2:0]  SP_IDX     = 3'h7;
  localparam int          FLAG_MASK_BIT = 7;
  localparam logic [7:0]  FLAGS_RST     = 8'h80;
  localparam logic [15:0] PC_STEP    = 16'h0002;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] PTR_STEP   = 16'h0001;

endpackage

//--- csb_mem_model.sv
// Purpose: Behavioural memory and peripheral space on the core's internal bus
// Assumes: Big-endian words; byte data travels on the low lane
// Notes:   Idle or unused read lanes show the inverse of the last read
`timescale 1ns/10ps
module csb_mem_model
(
  // Clock
  input  wire logic        clk,
  // Bus from the core
  input  wire logic        bus_valid,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_we,
  input  wire logic        bus_word,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata
);
  logic [7:0]  mem [0:65535];
  logic [15:0] last_q = 16'hA5A5;
  logic [15:0] rd_word;
  logic [15:0] addr_nxt;

  assign addr_nxt = bus_addr + 16'h0001;
  assign rd_word = bus_word ? {mem[bus_addr], mem[addr_nxt]} : {~last_q[15:8], mem[bus_addr]};
  assign bus_rdata = (bus_valid && !bus_we) ? rd_word : ~last_q;

  // Writes repeat each valid cycle with held data, so the last one wins
  always @(posedge clk)
  begin
    if (bus_valid && !bus_we)
      last_q <= rd_word;
    if (bus_valid && bus_we && bus_word)
    begin
      mem[bus_addr] <= bus_wdata[15:8];
      mem[addr_nxt] <= bus_wdata[7:0];
    end
    else if (bus_valid && bus_we)
      mem[bus_addr] <= bus_wdata[7:0];
  end
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the system-control and bus-timing core
// Assumes: Flags are seen through the interrupt push, registers through copies
// Notes:   Each row runs one op, then sleeps; an interrupt wakes and returns
`timescale 1ns/10ps
module tb_top;
  import csb_pkg::*;
  typedef struct packed {logic [7:0] op; logic [7:0] imm; logic [7:0] flags;} csb_row_t;
  logic        clk;
  logic        sys_rst;
  logic        bus_valid;
  logic        bus_we;
  logic        bus_word;
  logic        irq_req;
  logic        sub_clk_sel;
  logic        acc_word;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic [15:0] irq_vector;
  logic [15:0] acc_addr;
  logic [1:0]  run_mode_sel;
  logic [1:0]  run_mode;
  logic [2:0]  halt_mode_sel;
  logic [2:0]  halt_mode;
  csb_state_t  cpu_state;
  csb_row_t    rows [8];
  logic [15:0] tail [9];
  int          errors;
  int          num_checks;
  int          cyc;
  int          cnt;
  int          vec_len;

  csb_core csb_core_i (.clk(clk), .sys_rst(sys_rst), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_we(bus_we), .bus_word(bus_word), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .irq_req(irq_req), .irq_vector(irq_vector),
    .run_mode_sel(run_mode_sel), .halt_mode_sel(halt_mode_sel), .cpu_state(cpu_state),
    .run_mode(run_mode), .halt_mode(halt_mode), .sub_clk_sel(sub_clk_sel));

  csb_mem_model csb_mem_model_i (.clk(clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_we(bus_we), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] w);
    csb_mem_model_i.mem[a] = w[15:8];
    csb_mem_model_i.mem[a + 16'h0001] = w[7:0];
  endtask

  task automatic wait_state(input csb_state_t s);
    int n;
    n = 0;
    while (cpu_state !== s && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(cpu_state), 16'(s));
  endtask

  // Halt check, then interrupt wake with flags and counter push
  task automatic do_halt(input int i, input logic [7:0] flags, input logic [15:0] pc);
    wait_state(ST_HALT);
    chk(16'(halt_mode), 16'(i % 5));
    chk(16'(run_mode), 16'(i % 3));
    chk(16'(sub_clk_sel), 16'(i % 3 == 2));
    run_mode_sel = 2'((i + 1) % 3);
    halt_mode_sel = 3'((i + 1) % 5);
    irq_req = 1'b1;
    wait_state(ST_EXCEPT);
    wait_state(ST_EXEC);
    irq_req = 1'b0;
    chk(16'(csb_mem_model_i.mem[16'h005C]), 16'(flags));
    chk({csb_mem_model_i.mem[16'h005E], csb_mem_model_i.mem[16'h005F]}, pc);
  endtask

  // Every access: length in states and lane width by address
  always @(negedge clk)
  begin
    if (sys_rst === 1'b1)
      cnt = 0;
    else if (bus_valid === 1'b1)
    begin
      cnt++;
      acc_addr = bus_addr;
      acc_word = bus_word;
    end
    else if (cnt != 0)
    begin
      chk(16'(cnt), (acc_addr inside {[SLOW_A_LO:SLOW_A_HI], [SLOW_B_LO:SLOW_B_HI]}) ?
        16'(SLOW_STATES) : 16'(FAST_STATES));
      if (acc_addr >= PERIPH_BASE)
        chk(16'(acc_word), 16'h0000);
      if (acc_addr === irq_vector)
        vec_len = cnt;
      cnt = 0;
    end
  end

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    irq_req = 1'b0;
    irq_vector = 16'h0020;
    run_mode_sel = 2'h0;
    halt_mode_sel = 3'h0;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    cnt = 0;
    vec_len = 0;
    rows = '{'{OP_LOAD_FLAGS_IMM, 8'h3C, 8'h3C}, '{OP_OR_FLAGS, 8'h41, 8'h7D},
      '{OP_AND_FLAGS, 8'h56, 8'h54}, '{OP_XOR_FLAGS, 8'h2F, 8'h7B}, '{OP_NOP, 8'h00, 8'h7B},
      '{OP_STORE_FLAGS, 8'h04, 8'h7B}, '{OP_LOAD_FLAGS_IMM, 8'h11, 8'h11},
      '{OP_LOAD_FLAGS_REG, 8'h04, 8'h7B}};
    // Count 3, source 0040, destination 0050, then a zero-count copy
    tail = '{{OP_LOAD_FLAGS_IMM, 8'h03}, {OP_STORE_FLAGS, 5'h00, CNT_IDX},
      {OP_LOAD_FLAGS_IMM, 8'h40}, {OP_STORE_FLAGS, 5'h00, SRC_IDX},
      {OP_LOAD_FLAGS_IMM, 8'h50}, {OP_STORE_FLAGS, 5'h00, DST_IDX},
      {OP_BLK_COPY, 8'h00}, {OP_BLK_COPY, 8'h00}, {OP_SLEEP, 8'h00}};
    for (int a = 0; a < 65536; a++)
      csb_mem_model_i.mem[a] = 8'h00;
    put(RST_VEC_ADDR, 16'h0100);
    put(16'h0020, 16'h0200);
    put(16'h0200, {OP_RETURN, 8'h00});
    put(16'h0100, {OP_LOAD_FLAGS_IMM, 8'h60});
    put(16'h0102, {OP_STORE_FLAGS, 5'h00, SP_IDX});
    for (int i = 0; i < 8; i++)
    begin
      put(16'h0104 + 16'(4 * i), {rows[i].op, rows[i].imm});
      put(16'h0106 + 16'(4 * i), {OP_SLEEP, 8'h00});
    end
    for (int i = 0; i < 9; i++)
      put(16'h0124 + 16'(2 * i), tail[i]);
    put(16'h0040, 16'hA1B2);
    put(16'h0042, 16'hC3D4);
    put(16'h0050, 16'hEEEE);
    put(16'h0052, 16'hEEEE);
    repeat (8) @(negedge clk);
    chk(16'(bus_valid), 16'h0000);
    chk(16'(cpu_state), 16'(ST_RESET));
    sys_rst = 1'b0;
    @(negedge clk);
    chk(16'(cpu_state), 16'(ST_EXCEPT));
    for (int i = 0; i < 8; i++)
      do_halt(i, rows[i].flags, 16'h0108 + 16'(4 * i));
    // Slow peripheral vector read, then block copy results
    irq_vector = 16'hFF98;
    do_halt(8, 8'h50, 16'h0136);
    chk(16'(vec_len), 16'(SLOW_STATES));
    chk({csb_mem_model_i.mem[16'h0050], csb_mem_model_i.mem[16'h0051]}, 16'hA1B2);
    chk({csb_mem_model_i.mem[16'h0052], csb_mem_model_i.mem[16'h0053]}, 16'hC3EE);
    // Reset again in mid-run, then a fast peripheral vector read
    sys_rst = 1'b1;
    run_mode_sel = 2'h0;
    halt_mode_sel = 3'h0;
    irq_vector = PERIPH_BASE;
    repeat (3) @(negedge clk);
    chk(16'(bus_valid), 16'h0000);
    chk(16'(cpu_state), 16'(ST_RESET));
    sys_rst = 1'b0;
    do_halt(0, rows[0].flags, 16'h0108);
    chk(16'(vec_len), 16'(FAST_STATES));
    results();
  end
endmodule
